// ==== include/msd_pkg.sv ====
// Constants and types for the CPU memory space datapath
package msd_pkg;
  // ****************************************
  // Memory sizes and windows
  // ****************************************
  localparam int RAM_BYTES = 256; // Internal data RAM
  localparam int ON_CHIP_EXTENDED_RAM_BYTES = 1024; // On-chip extended RAM
  localparam logic [15:0] ON_CHIP_EXTENDED_RAM_BASE = 16'hf800; // First extended RAM address
  localparam logic [15:0] ON_CHIP_EXTENDED_RAM_LAST = 16'hfbff; // Last extended RAM address
  localparam logic [3:0] FLAG_BASE_HI = 4'h2; // Flag bytes sit at 0x20..0x2f
  // ****************************************
  // Special function space addresses
  // ****************************************
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_EXT_LATCH = 8'hc0; // Extension port latch and pins
  localparam logic [7:0] SFR_EXT_CTL = 8'hc1; // Block bits and port mode
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_B = 8'hf0;
  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [1:0] EXT_LATCH_RST = 2'b11;
  localparam int EXT_MODE_BIT = 3; // Mode bit in control register
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;
  // ****************************************
  // Operation encodings
  // ****************************************
  typedef enum logic [3:0] {
    K_STEP = 4'h0, K_JMP16 = 4'h1, K_BRREL = 4'h2, K_JMPIDX = 4'h3,
    K_LOOKUP = 4'h4, K_ALU = 4'h5, K_RD = 4'h6, K_WR = 4'h7,
    K_PUSH = 4'h8, K_POP = 4'h9, K_XRD = 4'ha, K_XWR = 4'hb,
    K_BITRD = 4'hc, K_BITWR = 4'hd
  } msd_kind_t;
  typedef enum logic [3:0] {
    A_ADD = 4'h0, A_SUBB = 4'h1, A_INC = 4'h2, A_DEC = 4'h3,
    A_DA = 4'h4, A_CMP = 4'h5, A_AND = 4'h6, A_OR = 4'h7,
    A_XOR = 4'h8, A_CPL = 4'h9, A_RL = 4'ha, A_RR = 4'hb,
    A_SWAP = 4'hc, A_MUL = 4'hd, A_DIV = 4'he
  } msd_alu_t;
  typedef enum logic [1:0] {
    AM_REG = 2'b00, AM_DIR = 2'b01, AM_IND = 2'b10, AM_IMM = 2'b11
  } msd_mode_t;
  // One operation request
  typedef struct packed {
    logic valid;
    msd_kind_t kind;
    msd_alu_t alu;
    msd_mode_t mode;
    logic dst_mem;
    logic [7:0] addr;
    logic [15:0] data;
  } msd_req_t;
  // Registered read answer
  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] data;
  } msd_rsp_t;
endpackage

// ==== logic/msd_core.sv ====
// CPU memory spaces, program counter and 8-bit arithmetic unit
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Low reset pin resets the processor
// RULE_02: Extension pins: quasi outputs or upper address
// RULE_03: Long jumps stay inside current 64K block
// RULE_04: Conditional branches are relative to counter
// RULE_05: Indexed jump adds index to base
// RULE_06: 256 RAM, 1024 extended, 128 special
// RULE_07: Four banks of eight working registers
// RULE_08: Flag bits live in bytes 32..47
// RULE_09: Extended RAM answers at 63488..64511
// RULE_10: Upper RAM indirect only, specials direct
// RULE_11: Unimplemented reads return undefined data
// RULE_12: Stack lives in RAM at pointer
// RULE_13: Other registers sit in special space
// RULE_14: Sixteen-bit counter moved by transfers
// RULE_15: Destinations register, direct or indirect only
// RULE_16: Unit makes 8-bit result from operands
// RULE_17: Full arithmetic and logic operation set
// RULE_18: Auxiliary register used by multiply, divide
// RULE_19: Direct address top bit picks specials
// RULE_20: Two bank bits pick bank at 8n
module msd_core (
  input wire logic clock, // 25 MHz core clock
  input wire logic reset_n, // Reset pin, low resets
  input msd_pkg::msd_req_t req, // One operation per cycle
  input wire logic branch_cond, // Condition of a relative branch
  input wire logic [1:0] extension_port_in, // Pin levels, bit0 is bit zero
  output msd_pkg::msd_rsp_t rsp, // Read answer, one cycle later
  output logic [18:0] code_addr, // Program memory address
  output logic [1:0] extension_port_out, // Pin output levels
  output logic [1:0] extension_port_oe // High while driving the pin
);
  import msd_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_r; // Release synchroniser
  logic rst_n_s; // Synchronised reset
  // Two flops release the reset to the clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00; // RULE_01
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[1];

  // ****************************************
  // State
  // ****************************************
  logic [7:0] ram [RAM_BYTES]; // RULE_06
  logic [7:0] on_chip_extended_ram [ON_CHIP_EXTENDED_RAM_BYTES]; // RULE_06
  logic [7:0] acc_r, b_r, psw_r, sp_r, dpl_r, dph_r;
  logic [2:0] blk_r; // Program block bits A16..A18
  logic ext_mode_r; // Extension pins carry address
  logic [1:0] ext_latch_r; // Quasi output latch
  logic [15:0] pc_r, pc_nxt; // RULE_14
  logic [15:0] data_pointer, idx_sum, rel_tgt;
  logic [1:0] bank; // Active register bank
  logic [7:0] ptr, sfr_val, src, wr_data, flag_byte;
  logic [8:0] ea, wr_addr; // Top bit selects special space
  logic [7:0] flag_idx, reg_idx;
  logic sfr_hit, wr_en, push_en, x_hit, alu_go;

  assign data_pointer = {dph_r, dpl_r};
  assign bank = psw_r[4:3];
  assign idx_sum = data_pointer + {8'h00, acc_r}; // RULE_05
  assign rel_tgt = pc_r + {{8{req.data[7]}}, req.data[7:0]}; // RULE_04
  assign flag_idx = {FLAG_BASE_HI, req.addr[6:3]}; // RULE_08
  assign reg_idx = {3'b000, bank, req.addr[2:0]}; // RULE_20
  assign x_hit = (data_pointer >= ON_CHIP_EXTENDED_RAM_BASE) && (data_pointer <= ON_CHIP_EXTENDED_RAM_LAST); // RULE_09
  assign alu_go = req.valid && (req.kind == K_ALU);

  // ****************************************
  // Operand addressing
  // ****************************************
  // Effective address, special register read, source operand
  always_comb begin
    ptr = ram[{3'b000, bank, 2'b00, req.addr[0]}]; // R0 or R1 pointer
    case (req.mode)
      AM_REG: ea = {1'b0, reg_idx}; // RULE_07
      AM_DIR: ea = {req.addr[7], req.addr}; // RULE_19 RULE_10
      AM_IND: ea = {1'b0, ptr}; // RULE_10
      default: ea = {1'b0, req.addr};
    endcase
    sfr_hit = 1'b1;
    case (ea[7:0]) // RULE_13
      SFR_ACC: sfr_val = acc_r;
      SFR_B: sfr_val = b_r;
      SFR_PSW: sfr_val = {psw_r[7:1], ^acc_r}; // Parity tracks accumulator
      SFR_SP: sfr_val = sp_r;
      SFR_DPL: sfr_val = dpl_r;
      SFR_DPH: sfr_val = dph_r;
      SFR_EXT_LATCH: sfr_val = {6'h00, extension_port_in};
      SFR_EXT_CTL: sfr_val = {4'h0, ext_mode_r, blk_r};
      default: begin
        sfr_val = 8'h00; // RULE_11
        sfr_hit = 1'b0;
      end
    endcase
    if (req.mode == AM_IMM) begin
      src = req.data[7:0];
    end else if (ea[8]) begin
      src = sfr_val;
    end else begin
      src = ram[ea[7:0]];
    end
  end

  // ****************************************
  // Arithmetic unit
  // ****************************************
  logic [7:0] alu_res, alu_b;
  logic fl_cy, fl_ac, fl_ov, fl_we, alu_wr;
  logic [15:0] prod;
  logic [8:0] da_t;
  // One 8-bit result per operation, plus a second byte for B on multiply and divide, flags beside it
  always_comb begin
    alu_res = acc_r; // RULE_16
    alu_b = b_r;
    fl_cy = psw_r[PSW_CY];
    fl_ac = psw_r[PSW_AC];
    fl_ov = psw_r[PSW_OV];
    fl_we = 1'b0;
    alu_wr = 1'b1;
    prod = acc_r * b_r;
    da_t = {1'b0, acc_r};
    case (req.alu) // RULE_17
      A_ADD: begin
        {fl_cy, alu_res} = {1'b0, acc_r} + {1'b0, src};
        fl_ac = ({1'b0, acc_r[3:0]} + {1'b0, src[3:0]}) > 5'h0f;
        fl_ov = (acc_r[7] == src[7]) && (alu_res[7] != acc_r[7]);
        fl_we = 1'b1;
      end
      A_SUBB: begin
        {fl_cy, alu_res} = {1'b0, acc_r} - {1'b0, src} - {8'h00, psw_r[PSW_CY]};
        fl_ac = {1'b0, acc_r[3:0]} < ({1'b0, src[3:0]} + {4'h0, psw_r[PSW_CY]});
        fl_ov = (acc_r[7] != src[7]) && (alu_res[7] != acc_r[7]);
        fl_we = 1'b1;
      end
      A_INC: alu_res = src + 8'h01;
      A_DEC: alu_res = src - 8'h01;
      A_DA: begin
        if ((acc_r[3:0] > 4'h9) || psw_r[PSW_AC]) begin
          da_t = da_t + 9'h006;
        end
        if ((da_t[7:4] > 4'h9) || da_t[8] || psw_r[PSW_CY]) begin
          da_t = da_t + 9'h060;
        end
        alu_res = da_t[7:0];
        fl_cy = psw_r[PSW_CY] | da_t[8];
        fl_we = 1'b1;
      end
      A_CMP: begin
        fl_cy = acc_r < src; // Flags only
        alu_wr = 1'b0;
        fl_we = 1'b1;
      end
      A_AND: alu_res = acc_r & src;
      A_OR: alu_res = acc_r | src;
      A_XOR: alu_res = acc_r ^ src;
      A_CPL: alu_res = ~acc_r;
      A_RL: alu_res = {acc_r[6:0], acc_r[7]};
      A_RR: alu_res = {acc_r[0], acc_r[7:1]};
      A_SWAP: alu_res = {acc_r[3:0], acc_r[7:4]};
      A_MUL: begin
        {alu_b, alu_res} = prod; // RULE_18
        fl_cy = 1'b0;
        fl_ov = |prod[15:8];
        fl_we = 1'b1;
      end
      A_DIV: begin
        fl_cy = 1'b0;
        fl_ov = (b_r == 8'h00); // Divide by zero gives all ones
        alu_res = fl_ov ? 8'hff : acc_r / b_r; // RULE_18
        alu_b = fl_ov ? 8'hff : acc_r % b_r;
        fl_we = 1'b1;
      end
      default: alu_wr = 1'b0;
    endcase
  end

  // ****************************************
  // Write selection
  // ****************************************
  // Picks the single byte written this cycle
  always_comb begin
    flag_byte = ram[flag_idx];
    flag_byte[req.addr[2:0]] = req.data[0];
    wr_en = 1'b0;
    wr_addr = ea;
    wr_data = req.data[7:0];
    push_en = req.valid && (req.kind == K_PUSH); // RULE_12
    if (req.valid) begin
      case (req.kind)
        K_WR: wr_en = (req.mode != AM_IMM); // RULE_15
        K_ALU: begin
          wr_en = req.dst_mem && alu_wr && (req.mode != AM_IMM); // RULE_15
          wr_data = alu_res;
        end
        K_POP: begin
          wr_en = (req.mode != AM_IMM);
          wr_data = ram[sp_r]; // RULE_12
        end
        K_BITWR: begin
          wr_en = !req.addr[7]; // RULE_08
          wr_addr = {1'b0, flag_idx};
          wr_data = flag_byte;
        end
        default: wr_en = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Memories
  // ****************************************
  // Data RAM: one write, or a push above the pointer
  always_ff @(posedge clock) begin
    if (rst_n_s && push_en) begin
      ram[sp_r + 8'h01] <= src; // RULE_12
    end else if (rst_n_s && wr_en && !wr_addr[8]) begin
      ram[wr_addr[7:0]] <= wr_data;
    end
  end
  // Extended RAM written from the accumulator
  always_ff @(posedge clock) begin
    if (rst_n_s && req.valid && (req.kind == K_XWR) && x_hit) begin
      on_chip_extended_ram[data_pointer[9:0]] <= acc_r; // RULE_09
    end
  end

  // ****************************************
  // Special function registers
  // ****************************************
  logic sfr_we;
  assign sfr_we = wr_en && wr_addr[8];
  // Accumulator and auxiliary register
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      acc_r <= 8'h00;
      b_r <= 8'h00;
    end else if (alu_go && ((req.alu == A_MUL) || (req.alu == A_DIV))) begin
      acc_r <= alu_res; // RULE_18
      b_r <= alu_b;
    end else if (sfr_we && (wr_addr[7:0] == SFR_ACC)) begin
      acc_r <= wr_data;
    end else if (sfr_we && (wr_addr[7:0] == SFR_B)) begin
      b_r <= wr_data; // RULE_18
    end else if (alu_go && alu_wr && !req.dst_mem) begin
      acc_r <= alu_res; // RULE_16
    end else if (req.valid && (req.kind == K_XRD) && x_hit) begin
      acc_r <= on_chip_extended_ram[data_pointer[9:0]]; // RULE_09
    end
  end
  // Status word: a direct write wins over flag updates
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      psw_r <= 8'h00;
    end else if (sfr_we && (wr_addr[7:0] == SFR_PSW)) begin
      psw_r <= wr_data; // RULE_20
    end else if (alu_go && fl_we) begin
      psw_r <= {fl_cy, fl_ac, psw_r[5:3], fl_ov, psw_r[1:0]};
    end
  end
  // Stack pointer, pointer halves and extension registers
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sp_r <= SP_RST;
      dpl_r <= 8'h00;
      dph_r <= 8'h00;
      blk_r <= 3'b000;
      ext_mode_r <= 1'b0;
      ext_latch_r <= EXT_LATCH_RST;
    end else if (sfr_we) begin
      // A pop into any special register still drops the pointer
      if (req.kind == K_POP) begin
        sp_r <= sp_r - 8'h01; // RULE_12
      end
      // A direct pointer write comes last, so it wins
      case (wr_addr[7:0])
        SFR_SP: sp_r <= wr_data;
        SFR_DPL: dpl_r <= wr_data;
        SFR_DPH: dph_r <= wr_data;
        SFR_EXT_LATCH: ext_latch_r <= wr_data[1:0];
        SFR_EXT_CTL: begin
          blk_r <= wr_data[2:0];
          ext_mode_r <= wr_data[EXT_MODE_BIT]; // RULE_02
        end
        default: ;
      endcase
    end else if (push_en) begin
      sp_r <= sp_r + 8'h01; // RULE_12
    end else if (req.valid && (req.kind == K_POP)) begin
      sp_r <= sp_r - 8'h01;
    end
  end

  // ****************************************
  // Program counter
  // ****************************************
  // Next counter value; the block bits never change here
  always_comb begin
    pc_nxt = pc_r;
    if (req.valid) begin
      case (req.kind)
        K_STEP: pc_nxt = pc_r + req.data; // RULE_14
        K_JMP16: pc_nxt = req.data; // RULE_03
        K_BRREL: pc_nxt = branch_cond ? rel_tgt : pc_r; // RULE_04
        K_JMPIDX: pc_nxt = idx_sum; // RULE_05
        default: pc_nxt = pc_r;
      endcase
    end
  end
  // Counter and program address register
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pc_r <= 16'h0000;
      code_addr <= 19'h00000;
    end else begin
      pc_r <= pc_nxt;
      if (req.valid && (req.kind == K_LOOKUP)) begin
        code_addr <= {blk_r, idx_sum}; // RULE_05
      end else begin
        code_addr <= {blk_r, pc_nxt}; // RULE_03
      end
    end
  end

  // ****************************************
  // Read answer and pins
  // ****************************************
  // Answer registered one cycle after the request
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid && (req.kind inside {K_RD, K_POP, K_XRD, K_BITRD, K_ALU});
      rsp.hit <= 1'b1;
      rsp.data <= src;
      case (req.kind)
        K_RD: rsp.hit <= !ea[8] || sfr_hit; // RULE_11
        K_POP: rsp.data <= ram[sp_r];
        K_XRD: begin
          rsp.hit <= x_hit;
          rsp.data <= x_hit ? on_chip_extended_ram[data_pointer[9:0]] : 8'h00;
        end
        K_BITRD: begin
          rsp.hit <= !req.addr[7];
          rsp.data <= {7'h00, ram[flag_idx][req.addr[2:0]] & !req.addr[7]};
        end
        K_ALU: rsp.data <= alu_res;
        default: rsp.hit <= 1'b0;
      endcase
    end
  end
  // Address mode drives UPPER_PROGRAM_ADDRESS_BITS, else quasi pins pull low only
  assign extension_port_out = ext_mode_r ? blk_r[2:1] : ext_latch_r; // RULE_02
  assign extension_port_oe = ext_mode_r ? 2'b11 : ~ext_latch_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n_s);
  logic vk_jmp, vk_br, vk_push, vk_xrd;
  assign vk_jmp = req.valid && (req.kind == K_JMP16);
  assign vk_br = req.valid && (req.kind == K_BRREL);
  assign vk_push = push_en && !sfr_we;
  assign vk_xrd = req.valid && (req.kind == K_XRD);
  AST_RESET_PC: assert property (disable iff (1'b0) !reset_n |=> pc_r == 16'h0000) // RULE_01
    else $error("counter not cleared by reset");
  AST_JMP_BLOCK: assert property (vk_jmp |=> code_addr[18:16] == $past(blk_r)) // RULE_03
    else $error("long jump left its block");
  AST_BRANCH: assert property (vk_br && branch_cond |=> pc_r == $past(rel_tgt)) // RULE_04
    else $error("relative branch target wrong");
  AST_INDEX: assert property (req.valid && req.kind == K_JMPIDX |=> pc_r == $past(idx_sum)) // RULE_05
    else $error("indexed jump target wrong");
  AST_ON_CHIP_EXTENDED_RAM_HIT: assert property (vk_xrd |=> rsp.valid && rsp.hit == $past(x_hit)) // RULE_09
    else $error("extended RAM window wrong");
  AST_PUSH_SP: assert property (vk_push |=> sp_r == $past(sp_r) + 8'h01) // RULE_12
    else $error("push did not raise pointer");
  AST_FLAG_BIT: assert property (req.valid && req.kind == K_BITWR && !req.addr[7]
      |=> ram[$past(flag_idx)] == $past(flag_byte)) // RULE_08
    else $error("flag bit not stored");
  AST_MUL: assert property (alu_go && req.alu == A_MUL
      |=> {b_r, acc_r} == $past(prod)) // RULE_18
    else $error("product not in B and A");
  AST_EXT_ADDR: assert property (ext_mode_r && $stable(blk_r) |-> extension_port_oe == 2'b11
      && extension_port_out == code_addr[18:17]) // RULE_02
    else $error("extension pins not carrying address");
  CV_MUL: cover property (alu_go && req.alu == A_MUL);
  CV_XRD: cover property (vk_xrd && x_hit);
  CV_BRANCH: cover property (vk_br && branch_cond);
endmodule

// ==== dv/msd_prog_mem.sv ====
// Program memory model that answers the core's code address
`timescale 1ns/1ps
module msd_prog_mem (
  input wire logic [18:0] code_addr, // Address from the core
  output logic [7:0] code_byte // Byte stored at that address
);
  // ****
  // Read path
  // ****
  // Contents are a fixed hash of the full 19-bit address, block bits too
  always_comb begin
    code_byte = code_addr[7:0] ^ code_addr[15:8] ^ {5'h0, code_addr[18:16]};
  end
endmodule

// ==== dv/cpu_memory_space_datapath_test.sv ====
// Self-checking bench for the memory space datapath
`timescale 1ns/1ps
module cpu_memory_space_datapath_test;
  import msd_pkg::*;
  // ****
  // Design hookup
  // ****
  logic clock = 1'b0; // Core clock
  logic reset_n = 1'b0; // Reset pin
  msd_req_t req = '0; // Request
  logic branch_cond = 1'b0; // Branch condition
  logic [1:0] extension_port_in = 2'b01; // Pin levels
  msd_rsp_t rsp; // Answer
  logic [18:0] code_addr; // Program address
  logic [1:0] extension_port_out; // Pin levels out
  logic [1:0] extension_port_oe; // Pin enables
  logic [7:0] code_byte; // Program memory byte
  int bad_count = 0; // Mismatches
  int check_count = 0; // Comparisons
  int cycles = 0; // Hang guard
  int ram[256]; // Model data RAM
  int on_chip_extended_ram[1024]; // Model extended RAM
  int a, b, program_status_word, sp, data_pointer, pc, ctl, latch, cy, ac, ov; // Model registers
  msd_core msd_core_i (.clock(clock), .reset_n(reset_n), .req(req), .branch_cond(branch_cond),
    .extension_port_in(extension_port_in), .rsp(rsp), .code_addr(code_addr),
    .extension_port_out(extension_port_out), .extension_port_oe(extension_port_oe));
  msd_prog_mem msd_prog_mem_i (.code_addr(code_addr), .code_byte(code_byte));
  always #20 clock = ~clock;
  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  // ****
  // Checking helpers
  // ****
  task automatic chk(string n, logic [18:0] e, logic [18:0] s);
    check_count++;
    if (e !== s) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic pins();
    logic [1:0] eo, ee;
    eo = (ctl & 8) ? 2'(ctl >> 1) : 2'(latch);
    ee = (ctl & 8) ? 2'b11 : 2'(~latch);
    chk("ext_out", 19'(eo), 19'(extension_port_out));
    chk("ext_oe", 19'(ee), 19'(extension_port_oe));
  endtask
  // ****
  // Reference model
  // ****
  // RAM index for register and indirect modes, in the active bank
  function automatic int rloc(int m, int ad);
    int r = ((program_status_word >> 3) & 3) * 8;
    return (m == AM_REG) ? r + (ad & 7) : ram[r + (ad & 1)];
  endfunction
  // Source value; -1 marks an unimplemented special location
  function automatic int rd(int m, int ad, int dt);
    if (m == AM_IMM) return dt & 255;
    if (m != AM_DIR || ad < 128) return ram[m == AM_DIR ? ad : rloc(m, ad)];
    case (ad)
      SFR_SP: return sp;
      SFR_DPL: return data_pointer & 255;
      SFR_DPH: return data_pointer >> 8;
      SFR_EXT_LATCH: return extension_port_in;
      SFR_EXT_CTL: return ctl;
      SFR_PSW: return (cy << 7) | (ac << 6) | (program_status_word & 8'h3a) | (ov << 2) | ($countones(a) & 1);
      SFR_ACC: return a;
      SFR_B: return b;
      default: return -1;
    endcase
  endfunction
  function automatic void wr(int m, int ad, int v);
    v &= 255;
    if (m == AM_IMM) return;
    if (m != AM_DIR || ad < 128) ram[m == AM_DIR ? ad : rloc(m, ad)] = v;
    else case (ad)
      SFR_SP: sp = v;
      SFR_DPL: data_pointer = (data_pointer & 16'hff00) | v;
      SFR_DPH: data_pointer = (data_pointer & 255) | (v << 8);
      SFR_EXT_LATCH: latch = v & 3;
      SFR_EXT_CTL: ctl = v & 15;
      SFR_PSW: begin
        program_status_word = v;
        cy = v >> 7;
        ac = (v >> 6) & 1;
        ov = (v >> 2) & 1;
      end
      SFR_ACC: a = v;
      SFR_B: b = v;
      default: ;
    endcase
  endfunction
  function automatic int alu(int op, int s);
    int r;
    case (op)
      A_ADD: begin
        r = a + s;
        ov = (~(a ^ s) & (a ^ r) & 128) != 0;
        ac = ((a & 15) + (s & 15)) > 15;
        cy = r > 255;
      end
      A_SUBB: begin
        r = a - s - cy;
        ov = ((a ^ s) & (a ^ r) & 128) != 0;
        ac = (a & 15) < (s & 15) + cy;
        cy = a < s + cy;
      end
      A_INC: r = s + 1;
      A_DEC: r = s - 1;
      A_DA: begin
        r = a;
        if ((r & 15) > 9 || ac) r += 6;
        if (r > 255) cy = 1;
        r &= 255;
        if ((r >> 4) > 9 || cy) r += 16'h60;
        if (r > 255) cy = 1;
      end
      A_CMP: begin
        r = a;
        cy = a < s;
      end
      A_AND: r = a & s;
      A_OR: r = a | s;
      A_XOR: r = a ^ s;
      A_CPL: r = ~a;
      A_RL: r = (a << 1) | (a >> 7);
      A_RR: r = (a >> 1) | ((a & 1) << 7);
      A_SWAP: r = (a << 4) | (a >> 4);
      A_MUL: begin
        r = a * b;
        ov = r > 255;
        b = (r >> 8) & 255;
        cy = 0;
      end
      default: begin
        ov = b == 0;
        cy = 0;
        r = (b == 0) ? 255 : a / b;
        b = (b == 0) ? 255 : a % b;
      end
    endcase
    return r & 255;
  endfunction
  // ****
  // One request, model update and comparison of every result
  // ****
  task automatic op(msd_kind_t k, msd_alu_t al, msd_mode_t m, logic dm, logic [7:0] ad,
                    logic [15:0] dt);
    int s, r, ev, ed, eh, ca, t;
    ev = 0;
    ed = -1;
    eh = -1;
    t = (data_pointer >= ON_CHIP_EXTENDED_RAM_BASE && data_pointer <= ON_CHIP_EXTENDED_RAM_LAST);
    ca = (ctl & 7) << 16; // Block bits as they stand before this request
    branch_cond = 1'($urandom);
    req = '{1'b1, k, al, m, dm, ad, dt};
    s = rd(m, ad, dt);
    case (k)
      K_STEP: pc += dt;
      K_JMP16: pc = dt;
      K_BRREL: if (branch_cond) pc += $signed(dt[7:0]);
      K_JMPIDX: pc = data_pointer + a;
      K_RD: begin
        ev = 1;
        ed = s;
        eh = s >= 0;
      end
      K_WR: wr(m, ad, dt);
      K_ALU: begin
        ev = 1;
        r = alu(al, s);
        if (al != A_CMP) ed = r;
        if (al == A_CMP) ;
        else if (dm && m != AM_IMM) wr(m, ad, r);
        else if (!dm) a = r;
      end
      K_PUSH: begin
        sp = (sp + 1) & 255;
        ram[sp] = s;
      end
      K_POP: begin
        ev = 1;
        ed = ram[sp];
        wr(m, ad, ed);
        sp = (sp - 1) & 255;
      end
      K_XRD: begin
        ev = 1;
        eh = t;
        if (t) ed = on_chip_extended_ram[data_pointer - ON_CHIP_EXTENDED_RAM_BASE];
      end
      K_XWR: if (t) on_chip_extended_ram[data_pointer - ON_CHIP_EXTENDED_RAM_BASE] = a;
      K_BITRD: begin
        ev = 1;
        eh = ad < 128;
        ed = (ad < 128) ? (ram[32 + (ad >> 3)] >> (ad & 7)) & 1 : 0;
      end
      K_BITWR: if (ad < 128) begin
        t = 32 + (ad >> 3);
        ram[t] = (ram[t] & ~(1 << (ad & 7))) | ((dt & 1) << (ad & 7));
      end
      default: ;
    endcase
    pc &= 16'hffff;
    ca |= (k == K_LOOKUP) ? (data_pointer + a) & 16'hffff : pc;
    @(posedge clock);
    #1;
    chk("rsp.valid", 19'(ev), 19'(rsp.valid));
    if (eh >= 0) chk("rsp.hit", 19'(eh), 19'(rsp.hit));
    if (ev && ed >= 0) chk("rsp.data", 19'(ed), 19'(rsp.data));
    chk("code_addr", 19'(ca), code_addr);
    pins();
  endtask
  task automatic rst();
    req = '0;
    reset_n = 1'b0;
    sp = SP_RST;
    latch = EXT_LATCH_RST;
    {ctl, program_status_word, cy, ac, ov, pc, data_pointer, a, b} = '0;
    repeat (6) @(posedge clock);
    #1;
    chk("code_addr", 19'h0, code_addr);
    chk("rsp.valid", 19'h0, 19'(rsp.valid));
    pins();
    reset_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    op(K_RD, A_ADD, AM_DIR, 0, SFR_SP, 0);
    $display("test reset ended, mismatches %0d", bad_count);
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    logic [7:0] v;
    logic [15:0] xa[4];
    void'($urandom(32'h9977175c));
    xa = '{16'hf7ff, ON_CHIP_EXTENDED_RAM_BASE, ON_CHIP_EXTENDED_RAM_LAST, 16'hfc00};
    rst();
    for (int n = 0; n < 4; n++) begin
      v = 8'($urandom_range(255, 48));
      op(K_WR, A_ADD, AM_DIR, 0, SFR_PSW, 16'(n << 3));
      op(K_WR, A_ADD, AM_REG, 0, 8'h5, 16'($urandom));
      op(K_RD, A_ADD, AM_DIR, 0, 8'(8 * n + 5), 0);
      op(K_WR, A_ADD, AM_REG, 0, 8'(n & 1), 16'(v));
      op(K_WR, A_ADD, AM_IND, 0, 8'(n & 1), 16'($urandom));
      op(K_RD, A_ADD, AM_IND, 0, 8'(n & 1), 0);
      op(K_RD, A_ADD, AM_DIR, 0, v, 0);
    end
    op(K_RD, A_ADD, AM_DIR, 0, 8'h90, 0);
    for (int i = 32; i < 48; i++) op(K_WR, A_ADD, AM_DIR, 0, 8'(i), 16'($urandom));
    repeat (8) begin
      v = 8'($urandom_range(127, 0));
      op(K_BITWR, A_ADD, AM_DIR, 0, v, 16'($urandom));
      op(K_BITRD, A_ADD, AM_DIR, 0, v, 0);
      op(K_RD, A_ADD, AM_DIR, 0, 8'(32 + v[6:3]), 0);
    end
    op(K_BITWR, A_ADD, AM_DIR, 0, 8'h85, 16'h1);
    op(K_BITRD, A_ADD, AM_DIR, 0, 8'h85, 0);
    repeat (3) begin
      op(K_WR, A_ADD, AM_DIR, 0, SFR_B, 16'($urandom));
      op(K_PUSH, A_ADD, AM_DIR, 0, SFR_B, 0);
    end
    repeat (3) op(K_POP, A_ADD, AM_DIR, 0, 8'h50, 0);
    op(K_RD, A_ADD, AM_DIR, 0, SFR_SP, 0);
    $display("test memory ended, mismatches %0d", bad_count);
    for (int i = 0; i < 45; i++) begin
      op(K_WR, A_ADD, AM_DIR, 0, SFR_ACC, 16'($urandom));
      op(K_WR, A_ADD, AM_DIR, 0, SFR_B, 16'((i % 4) ? $urandom_range(255, 1) : 0));
      v = 8'(i % 15);
      op(K_ALU, msd_alu_t'(v[3:0]), (v > 12) ? AM_DIR : AM_IMM, 0, SFR_B,
         16'($urandom));
      op(K_RD, A_ADD, AM_DIR, 0, SFR_B, 0);
      op(K_RD, A_ADD, AM_DIR, 0, SFR_PSW, 0);
    end
    op(K_WR, A_ADD, AM_DIR, 0, 8'h30, 16'($urandom));
    op(K_ALU, A_INC, AM_DIR, 1, 8'h30, 0);
    op(K_RD, A_ADD, AM_DIR, 0, 8'h30, 0);
    op(K_ALU, A_ADD, AM_IMM, 1, 8'h30, 16'h5);
    $display("test arithmetic ended, mismatches %0d", bad_count);
    foreach (xa[i]) begin
      v = 8'($urandom);
      op(K_WR, A_ADD, AM_DIR, 0, SFR_DPH, 16'(xa[i] >> 8));
      op(K_WR, A_ADD, AM_DIR, 0, SFR_DPL, 16'(xa[i] & 16'hff));
      op(K_WR, A_ADD, AM_DIR, 0, SFR_ACC, 16'(v));
      op(K_XWR, A_ADD, AM_IMM, 0, 0, 16'(v));
      op(K_XRD, A_ADD, AM_IMM, 0, 0, 0);
    end
    $display("test extended ram ended, mismatches %0d", bad_count);
    op(K_WR, A_ADD, AM_DIR, 0, SFR_EXT_CTL, 16'h0d);
    op(K_JMP16, A_ADD, AM_IMM, 0, 0, 16'($urandom));
    op(K_STEP, A_ADD, AM_IMM, 0, 0, 16'h3);
    repeat (6) op(K_BRREL, A_ADD, AM_IMM, 0, 0, 16'($urandom));
    op(K_WR, A_ADD, AM_DIR, 0, SFR_ACC, 16'($urandom));
    op(K_JMPIDX, A_ADD, AM_IMM, 0, 0, 0);
    op(K_LOOKUP, A_ADD, AM_IMM, 0, 0, 0);
    chk("code_byte", 19'(code_addr[7:0] ^ code_addr[15:8] ^ 8'h5), 19'(code_byte));
    op(K_STEP, A_ADD, AM_IMM, 0, 0, 0);
    op(K_WR, A_ADD, AM_DIR, 0, SFR_EXT_CTL, 16'h05);
    op(K_WR, A_ADD, AM_DIR, 0, SFR_EXT_LATCH, 16'h01);
    extension_port_in = 2'b10;
    op(K_RD, A_ADD, AM_DIR, 0, SFR_EXT_LATCH, 0);
    $display("test program counter ended, mismatches %0d", bad_count);
    rst();
    wrap_up();
  end
endmodule
